// [core/ptlm_pkg.sv]
/*
 * Constants, chunk type and lane functions of the PCI target lane mapper.
 * Assumes nothing of its surroundings; shared by all mapper modules except ptlm_cpl_buf.
 */
package ptlm_pkg;

    // ************************************************************
    // Codes
    // ************************************************************
    localparam logic [1:0] SIZE_BYTE = 2'h1;
    localparam logic [1:0] SIZE_HALF = 2'h2;
    localparam logic [1:0] SIZE_WORD = 2'h0;
    localparam logic [1:0] PW_32     = 2'h0;
    localparam logic [1:0] PW_16     = 2'h1;
    localparam logic [1:0] PW_8      = 2'h2;
    localparam logic       ORDER_BIG = 1'h0;
    localparam logic [3:0] MASK_NONE = 4'h0;
    localparam logic [3:0] MASK_WORD = 4'hF;
    localparam logic [3:0] MASK_LO   = 4'h3;
    localparam logic [3:0] MASK_HI   = 4'hC;
    localparam logic [1:0] ADDR_LO   = 2'h0;
    localparam logic [1:0] ADDR_HI   = 2'h2;
    localparam int         CPL_W     = 33;

    typedef struct packed {
        logic [1:0] size;
        logic [1:0] a;
        logic [3:0] mask;
    } ptlm_chunk_t;

    // ************************************************************
    // Functions
    // ************************************************************
    // PCI byte lane that holds local byte address a
    function automatic logic [1:0] pci_byte(input logic [1:0] a, input logic le);
        pci_byte = le ? 2'(2'h3 - a) : a;
    endfunction

    // Byte enables re-ordered by local byte address
    function automatic logic [3:0] addr_mask(input logic [3:0] sel, input logic le);
        addr_mask = MASK_NONE;
        for (int i = 0; i < 4; i++) begin
            addr_mask[i] = sel[pci_byte(2'(i), le)];
        end
    endfunction

    function automatic logic is_regular(input logic [3:0] m);
        is_regular = (m == MASK_WORD) || (m == MASK_LO) || (m == MASK_HI) || ($countones(m) == 1);
    endfunction

    // Next local cycle: lowest address first
    function automatic ptlm_chunk_t pick(input logic [3:0] m, input logic [1:0] pw, input logic bytes_only);
        pick = '{size: SIZE_BYTE, a: ADDR_LO, mask: MASK_NONE};
        if (!bytes_only && pw != PW_16 && m == MASK_WORD) begin
            pick = '{size: SIZE_WORD, a: ADDR_LO, mask: MASK_WORD};
        end else if (!bytes_only && m[1:0] == MASK_LO[1:0]) begin
            pick = '{size: SIZE_HALF, a: ADDR_LO, mask: MASK_LO};
        end else if (!bytes_only && m == MASK_HI) begin
            pick = '{size: SIZE_HALF, a: ADDR_HI, mask: MASK_HI};
        end else begin
            for (int i = 3; i >= 0; i--) begin
                if (m[i]) begin
                    pick.a    = 2'(i);
                    pick.mask = 4'(1 << i);
                end
            end
        end
    endfunction

endpackage

// [core/ptlm_stream_if.sv]
/*
 * Valid/ready word stream between the mapper and its completion buffer.
 * Assumes one clock shared by both ends.
 */
`timescale 1ns/1ps
`default_nettype none
interface ptlm_stream_if #(parameter int W = 33);
    logic         valid;
    logic         ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// [core/ptlm_cpl_buf.sv]
/*
 * Two-entry completion buffer; head entry drives the outputs from flops.
 * Assumes the drain side may stall indefinitely.
 */
`timescale 1ns/1ps
`default_nettype none
module ptlm_cpl_buf #(
    parameter int W = 33
) (
    // Clock and reset
    input  wire logic         clock_i,
    input  wire logic         rst_i,
    // Fill side
    ptlm_stream_if.snk        in_s,
    // Drain side
    output var  logic         out_valid_o,
    output var  logic [W-1:0] out_data_o,
    input  wire logic         out_ready_i
);
    logic         full;
    logic [W-1:0] spare;
    logic         pop;
    logic         push;

    assign in_s.ready = !full;
    assign pop        = out_valid_o && out_ready_i;
    assign push       = in_s.valid && !full;

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            out_valid_o <= 1'b0;
            out_data_o  <= '0;
            full        <= 1'b0;
            spare       <= '0;
        end else if (pop && full) begin
            out_data_o <= spare;
            full       <= 1'b0;
        end else if (pop) begin
            out_valid_o <= push;
            out_data_o  <= in_s.data;
        end else if (push && !out_valid_o) begin
            out_valid_o <= 1'b1;
            out_data_o  <= in_s.data;
        end else if (push) begin
            full  <= 1'b1;
            spare <= in_s.data;
        end
    end
endmodule // ptlm_cpl_buf
`default_nettype wire

// [core/ptlm_lane_map.sv]
/*
 * Combinational lane steering for one local cycle: write replication and
 * read capture into PCI lanes. Assumes chunks come from ptlm_pkg::pick.
 */
`timescale 1ns/1ps
`default_nettype none
module ptlm_lane_map (
    // Write side
    input  wire logic                wr_le_i,
    input  wire ptlm_pkg::ptlm_chunk_t wr_chunk_i,
    input  wire logic [31:0]         pci_wdata_i,
    output logic [31:0]              lb_wdata_o,
    // Read side
    input  wire logic                rd_le_i,
    input  wire logic [1:0]          rd_width_i,
    input  wire ptlm_pkg::ptlm_chunk_t rd_chunk_i,
    input  wire logic [31:0]         lb_rdata_i,
    output logic [31:0]              rd_bytes_o
);
    logic [7:0] ab [4];
    logic [7:0] x;
    logic [1:0] lane;

    always_comb begin
        for (int i = 0; i < 4; i++) begin
            ab[i] = pci_wdata_i[8*ptlm_pkg::pci_byte(2'(i), wr_le_i) +: 8];
        end
        x          = ab[wr_chunk_i.a];
        lb_wdata_o = '0;
        if (wr_chunk_i.size == ptlm_pkg::SIZE_WORD) begin
            lb_wdata_o = {ab[0], ab[1], ab[2], ab[3]};
        end else if (wr_chunk_i.size == ptlm_pkg::SIZE_HALF) begin
            lb_wdata_o[31:16] = {x, ab[2'(wr_chunk_i.a + 2'h1)]};
            if (wr_chunk_i.a == ptlm_pkg::ADDR_HI) begin
                lb_wdata_o[15:0] = {ab[2], ab[3]};
            end
        end else begin
            lb_wdata_o[31:24] = x;
            if (wr_chunk_i.a[0]) begin
                lb_wdata_o[23:16] = x;
            end
            if (wr_chunk_i.a == 2'h2) begin
                lb_wdata_o[15:8] = x;
            end
            if (wr_chunk_i.a == 2'h3) begin
                lb_wdata_o[7:0] = x;
            end
        end
    end

    // Unselected PCI lanes read back as zero
    always_comb begin
        rd_bytes_o = '0;
        lane       = 2'h3;
        for (int i = 0; i < 4; i++) begin
            if (rd_width_i == ptlm_pkg::PW_16) begin
                lane = 2'(2'h3 - {1'b0, i[0]});
            end else if (rd_width_i == ptlm_pkg::PW_8) begin
                lane = 2'h3;
            end else begin
                lane = 2'(3 - i);
            end
            if (rd_chunk_i.mask[i]) begin
                rd_bytes_o[8*ptlm_pkg::pci_byte(2'(i), rd_le_i) +: 8] = lb_rdata_i[8*lane +: 8];
            end
        end
    end
endmodule // ptlm_lane_map
`default_nettype wire

// [core/ptlm_lane_mapper.sv]
/*
 * PCI target lane mapper: turns one PCI target write or delayed read
 * into zero or more local processor bus cycles with size code, low
 * address bits and steered data, then returns one completion.
 * Assumes the request is held stable until taken, that the local bus
 * answers each cycle with lb_ready_i, and one common clock.
 */
`timescale 1ns/1ps
`default_nettype none
module ptlm_lane_mapper (
    // Clock and reset
    input  wire logic        clock_i,
    input  wire logic        rst_i,
    // PCI target request
    input  wire logic        req_valid_i,
    output var  logic        req_ready_o,
    input  wire logic        req_write_i,
    input  wire logic [31:0] req_addr_i,
    input  wire logic [3:0]  req_be_n_i,
    input  wire logic [31:0] req_data_i,
    // Image and global mode
    input  wire logic        global_byte_order_select_i,
    input  wire logic        image_order_invert_i,
    input  wire logic [1:0]  port_width_field_i,
    // Local processor bus master
    output var  logic        lb_valid_o,
    input  wire logic        lb_ready_i,
    output var  logic        lb_write_o,
    output var  logic [31:0] lb_addr_o,
    output var  logic [1:0]  transfer_size_code_o,
    output var  logic [31:0] lb_wdata_o,
    input  wire logic [31:0] lb_rdata_i,
    // Completion to PCI side
    output var  logic        cpl_valid_o,
    input  wire logic        cpl_ready_i,
    output var  logic        cpl_write_o,
    output var  logic [31:0] cpl_rdata_o
);

    // ************************************************************
    // Declarations
    // ************************************************************
    typedef enum logic [2:0] {
        ST_IDLE  = 3'h1,
        ST_ISSUE = 3'h2,
        ST_DONE  = 3'h4
    } ptlm_state_t;

    ptlm_state_t           state;
    logic                  le;
    logic                  bytes_only;
    logic [1:0]            width;
    logic                  wr;
    logic [29:0]           addr_hi;
    logic [31:0]           wdata;
    logic [3:0]            rem;
    ptlm_pkg::ptlm_chunk_t cur;
    logic [31:0]           acc;

    logic                  take;
    logic                  ack;
    logic                  next_le;
    logic [1:0]            next_width;
    logic                  next_bytes_only;
    logic [3:0]            next_rem;
    ptlm_pkg::ptlm_chunk_t next_chunk;
    logic [31:0]           next_src;
    logic [31:0]           next_wdata;
    logic [31:0]           rd_bytes;
    logic [32:0]           cpl_data;

    ptlm_stream_if #(.W(ptlm_pkg::CPL_W)) cpl_s ();

    assign take = req_valid_i && req_ready_o;
    assign ack  = lb_valid_o && lb_ready_i;

    // ************************************************************
    // Mode and next cycle selection
    // ************************************************************
    // Order: global select xor image invert, taken per request
    assign next_le = (global_byte_order_select_i != ptlm_pkg::ORDER_BIG) ^ image_order_invert_i;

    always_comb begin
        if (state == ST_IDLE) begin
            next_width      = port_width_field_i;
            next_rem        = ptlm_pkg::addr_mask(~req_be_n_i, next_le);
            next_bytes_only = !ptlm_pkg::is_regular(next_rem) || next_width == ptlm_pkg::PW_8;
            next_src        = req_data_i;
        end else begin
            next_width      = width;
            next_rem        = rem & ~cur.mask;
            next_bytes_only = bytes_only;
            next_src        = wdata;
        end
        next_chunk = ptlm_pkg::pick(next_rem, next_width, next_bytes_only);
    end

    ptlm_lane_map u_map (
        .wr_le_i     (state == ST_IDLE ? next_le : le),
        .wr_chunk_i  (next_chunk),
        .pci_wdata_i (next_src),
        .lb_wdata_o  (next_wdata),
        .rd_le_i     (le),
        .rd_width_i  (width),
        .rd_chunk_i  (cur),
        .lb_rdata_i  (lb_rdata_i),
        .rd_bytes_o  (rd_bytes)
    );

    // ************************************************************
    // Sequencer
    // ************************************************************
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            state       <= ST_IDLE;
            req_ready_o <= 1'b1;
            lb_valid_o  <= 1'b0;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (take) begin
                        req_ready_o <= 1'b0;
                        if (next_rem == ptlm_pkg::MASK_NONE) begin
                            state <= ST_DONE;
                        end else begin
                            state      <= ST_ISSUE;
                            lb_valid_o <= 1'b1;
                        end
                    end
                end
                ST_ISSUE: begin
                    // Completion only once the last split cycle is answered
                    if (ack && next_rem == ptlm_pkg::MASK_NONE) begin
                        state      <= ST_DONE;
                        lb_valid_o <= 1'b0;
                    end
                end
                ST_DONE: begin
                    if (cpl_s.ready) begin
                        state       <= ST_IDLE;
                        req_ready_o <= 1'b1;
                    end
                end
                default: begin
                    state       <= ST_IDLE;
                    req_ready_o <= 1'b1;
                    lb_valid_o  <= 1'b0;
                end
            endcase
        end
    end

    // ************************************************************
    // Request capture
    // ************************************************************
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            le         <= 1'b0;
            bytes_only <= 1'b0;
            width      <= ptlm_pkg::PW_32;
            wr         <= 1'b0;
            addr_hi    <= '0;
            wdata      <= '0;
        end else if (take) begin
            le         <= next_le;
            bytes_only <= next_bytes_only;
            width      <= next_width;
            wr         <= req_write_i;
            addr_hi    <= req_addr_i[31:2];
            wdata      <= req_data_i;
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            rem <= ptlm_pkg::MASK_NONE;
            cur <= '0;
        end else if (take || ack) begin
            rem <= next_rem;
            cur <= next_chunk;
        end
    end

    // ************************************************************
    // Local bus cycle registers
    // ************************************************************
    // Reloaded on the answer so split cycles follow back to back
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            lb_write_o           <= 1'b0;
            lb_addr_o            <= '0;
            transfer_size_code_o <= ptlm_pkg::SIZE_WORD;
            lb_wdata_o           <= '0;
        end else if ((take || ack) && next_rem != ptlm_pkg::MASK_NONE) begin
            lb_write_o           <= (state == ST_IDLE) ? req_write_i : wr;
            lb_addr_o            <= {(state == ST_IDLE) ? req_addr_i[31:2] : addr_hi, next_chunk.a};
            transfer_size_code_o <= next_chunk.size;
            lb_wdata_o           <= next_wdata;
        end
    end

    // ************************************************************
    // Read packing
    // ************************************************************
    // Each answered read merges its bytes; writes leave it zero
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            acc <= '0;
        end else if (take) begin
            acc <= '0;
        end else if (ack && !wr) begin
            acc <= acc | rd_bytes;
        end
    end

    // ************************************************************
    // Completion buffer
    // ************************************************************
    // A stalled receiver holds the sequencer in ST_DONE, nothing is dropped
    assign cpl_s.valid = (state == ST_DONE);
    assign cpl_s.data  = {wr, acc};

    ptlm_cpl_buf #(.W(ptlm_pkg::CPL_W)) u_buf (
        .clock_i     (clock_i),
        .rst_i       (rst_i),
        .in_s        (cpl_s.snk),
        .out_valid_o (cpl_valid_o),
        .out_data_o  (cpl_data),
        .out_ready_i (cpl_ready_i)
    );

    assign cpl_write_o = cpl_data[32];
    assign cpl_rdata_o = cpl_data[31:0];

endmodule // ptlm_lane_mapper
`default_nettype wire

// [verification/ptlm_lane_mapper_chk.sv]
/*
 * Concurrent checks on the lane mapper's top-level ports.
 * Assumes one clock and an active-high asynchronous reset.
 */
`timescale 1ns/1ps
`default_nettype none
module ptlm_lane_mapper_chk (
    // Clock and reset
    input wire logic        clock_i,
    input wire logic        rst_i,
    // Request
    input wire logic        req_valid_i,
    input wire logic        req_ready_o,
    // Local bus
    input wire logic        lb_valid_o,
    input wire logic        lb_ready_i,
    input wire logic        lb_write_o,
    input wire logic [31:0] lb_addr_o,
    input wire logic [1:0]  transfer_size_code_o,
    input wire logic [31:0] lb_wdata_o,
    // Completion
    input wire logic        cpl_valid_o,
    input wire logic        cpl_ready_i,
    input wire logic        cpl_write_o,
    input wire logic [31:0] cpl_rdata_o
);
    // ******************
    // Properties
    // ******************
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i);

    reset_idle_a: assert property ($fell(rst_i) |-> req_ready_o && !lb_valid_o && !cpl_valid_o)
        else $error("mapper not idle after reset");
    take_busy_a: assert property (req_valid_i && req_ready_o |=> !req_ready_o)
        else $error("mapper still ready after a take");
    take_start_a: assert property (req_valid_i && req_ready_o |-> ##[1:2] (lb_valid_o || cpl_valid_o))
        else $error("no local cycle or completion after a take");
    lb_hold_a: assert property (lb_valid_o && !lb_ready_i |=> lb_valid_o &&
        $stable({lb_write_o, lb_addr_o, transfer_size_code_o, lb_wdata_o})) else $error("local cycle changed");
    size_legal_a: assert property (lb_valid_o |-> transfer_size_code_o != 2'h3)
        else $error("illegal size code");
    align_a: assert property (lb_valid_o && transfer_size_code_o != ptlm_pkg::SIZE_BYTE |->
        !lb_addr_o[0] && (transfer_size_code_o == ptlm_pkg::SIZE_HALF || !lb_addr_o[1]))
        else $error("misaligned local cycle");
    ascend_a: assert property (lb_valid_o && lb_ready_i |=>
        !lb_valid_o || lb_addr_o[1:0] > $past(lb_addr_o[1:0])) else $error("split cycles not ascending");
    idle_quiet_a: assert property (req_ready_o |-> !lb_valid_o)
        else $error("local cycle while idle");
    rep_byte3_a: assert property (lb_valid_o && lb_write_o && lb_addr_o[1:0] == 2'h3 &&
        transfer_size_code_o == ptlm_pkg::SIZE_BYTE |-> lb_wdata_o[31:24] == lb_wdata_o[7:0] &&
        lb_wdata_o[23:16] == lb_wdata_o[7:0]) else $error("byte three not replicated");
    rep_half_a: assert property (lb_valid_o && lb_write_o && lb_addr_o[1:0] == 2'h2 &&
        transfer_size_code_o == ptlm_pkg::SIZE_HALF |-> lb_wdata_o[31:16] == lb_wdata_o[15:0])
        else $error("half not replicated");
    wr_zero_a: assert property (cpl_valid_o && cpl_write_o |-> cpl_rdata_o == 32'h0)
        else $error("write completion carries data");
    cpl_hold_a: assert property (cpl_valid_o && !cpl_ready_i |=> cpl_valid_o &&
        $stable({cpl_write_o, cpl_rdata_o})) else $error("completion changed before taken");
endmodule // ptlm_lane_mapper_chk

bind ptlm_lane_mapper ptlm_lane_mapper_chk u_chk (.*);
`default_nettype wire

// [verification/ptlm_lb_model.sv]
/*
 * Local bus peripheral model: the byte at local address x reads as D0+x.
 * Assumes the mapper holds each cycle until lb_ready_o.
 */
`timescale 1ns/1ps
`default_nettype none
module ptlm_lb_model (
    // Clock and reset
    input  wire logic        clock_i,
    input  wire logic        rst_i,
    // Mode
    input  wire logic [1:0]  width_i,
    input  wire logic        slow_i,
    // Local bus slave
    input  wire logic        lb_valid_i,
    input  wire logic [31:0] lb_addr_i,
    output logic             lb_ready_o,
    output logic [31:0]      lb_rdata_o
);
    // ******************
    // Answer
    // ******************
    logic [1:0]  wait_cnt;
    logic [15:0] noise;
    logic [1:0]  a;
    logic [31:0] word;

    assign a = lb_addr_i[1:0];
    assign lb_ready_o = lb_valid_i && wait_cnt == (slow_i ? 2'h2 : 2'h0);
    // Outside the answer the lanes carry the inverse, so stale data never matches
    assign lb_rdata_o = lb_ready_o ? word : ~word;

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            wait_cnt <= 2'h0;
            noise <= 16'h0;
        end else begin
            wait_cnt <= (lb_valid_i && !lb_ready_o) ? 2'(wait_cnt + 2'h1) : 2'h0;
            noise <= 16'(noise + 16'h3);
        end
    end

    // Narrow ports use the upper lanes only; the rest is noise
    always_comb begin
        case (width_i)
            ptlm_pkg::PW_16: word = {6'h34, a[1], 1'h0, 6'h34, a[1], 1'h1, noise};
            ptlm_pkg::PW_8:  word = {6'h34, a, noise, noise[7:0]};
            default:         word = 32'hD0D1_D2D3;
        endcase
    end
endmodule // ptlm_lb_model
`default_nettype wire

// [verification/tb.sv]
/*
 * Self-checking bench of the lane mapper: table of requests, then buffer
 * full and reset in mid-cycle. Assumes ptlm_lb_model on the local bus.
 */
`timescale 1ns/1ps
`default_nettype none
module tb;
    // ******************
    // Signals
    // ******************
    typedef struct packed {
        logic [3:0] wr, be_n, gbos, inv, pw, n, slow;
    } ptlm_row_t;
    typedef struct packed {
        logic w; logic [31:0] a; logic [1:0] s; logic [31:0] d;
    } ptlm_log_t;
    localparam logic [31:0] ADDR = 32'h1234_5677;
    localparam logic [31:0] WDATA = 32'hB3B2_B1B0;
    logic        clock_i = 1'h0;
    logic        rst_i = 1'h1;
    logic        req_valid_i = 1'h0;
    logic        req_write_i = 1'h0;
    logic [31:0] req_addr_i = ADDR;
    logic [3:0]  req_be_n_i = 4'h0;
    logic [31:0] req_data_i = WDATA;
    logic        global_byte_order_select_i = 1'h0;
    logic        image_order_invert_i = 1'h0;
    logic [1:0]  port_width_field_i = 2'h0;
    logic        cpl_ready_i = 1'h0;
    logic        slow = 1'h0;
    logic        req_ready_o, lb_valid_o, lb_ready_i, lb_write_o, cpl_valid_o, cpl_write_o;
    logic [31:0] lb_addr_o, lb_wdata_o, lb_rdata_i, cpl_rdata_o;
    logic [1:0]  transfer_size_code_o;
    int          n_mismatch = 0;
    int          n_compared = 0;
    int          cycles = 0;
    ptlm_log_t   lg [$];
    logic [1:0]  qs [$];
    logic [1:0]  qa [$];
    // Digits: write, be_n, order, invert, width, cycles, slow
    ptlm_row_t rows [33] = '{
        28'h1010010, 28'h1710010, 28'h1B10011, 28'h1D10010, 28'h1E10010, 28'h1310010,
        28'h1C10010, 28'h1000010, 28'h1C11010, 28'h1300010, 28'h1700010, 28'h1810030,
        28'h1A00020, 28'h1910020, 28'h1000121, 28'h1310110, 28'h1010240, 28'h1C01220,
        28'h1F10000, 28'h1000310, 28'h0010010, 28'h0000011, 28'h0B00010, 28'h0310010,
        28'h0410030, 28'h0010120, 28'h0000121, 28'h0300110, 28'h0D10110, 28'h0E10110,
        28'h0600120, 28'h0010240, 28'h0F00000};

    ptlm_lane_mapper u_dut (.*);
    ptlm_lb_model u_model (.clock_i(clock_i), .rst_i(rst_i), .width_i(port_width_field_i), .slow_i(slow),
        .lb_valid_i(lb_valid_o), .lb_addr_i(lb_addr_o), .lb_ready_o(lb_ready_i), .lb_rdata_o(lb_rdata_i));

    always #12.5 clock_i = ~clock_i;

    always @(posedge clock_i) begin
        if (lb_valid_o === 1'h1 && lb_ready_i === 1'h1)
            lg.push_back('{lb_write_o, lb_addr_o, transfer_size_code_o, lb_wdata_o});
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            n_mismatch++;
            report_and_stop();
        end
    end

    // ******************
    // Reference and tasks
    // ******************
    function automatic void plan(input logic [3:0] sel, input logic le, input logic [1:0] pw);
        logic [3:0] m;
        qs.delete();
        qa.delete();
        for (int a = 0; a < 4; a++) m[a] = sel[le ? 3 - a : a];
        if (m == 4'h0) return;
        if (pw == ptlm_pkg::PW_8 || !(m == 4'hF || m == 4'h3 || m == 4'hC)) begin
            for (int a = 0; a < 4; a++) if (m[a]) begin
                qs.push_back(ptlm_pkg::SIZE_BYTE);
                qa.push_back(2'(a));
            end
        end else if (m == 4'hF && pw != ptlm_pkg::PW_16) begin
            qs.push_back(ptlm_pkg::SIZE_WORD);
            qa.push_back(2'h0);
        end else begin
            for (int a = 0; a < 4; a += 2) if (m[a]) begin
                qs.push_back(ptlm_pkg::SIZE_HALF);
                qa.push_back(2'(a));
            end
        end
    endfunction

    function automatic logic [31:0] ew(input logic [1:0] s, input logic [1:0] a, input logic le);
        logic [7:0]  v [4];
        logic [15:0] h;
        for (int x = 0; x < 4; x++) v[x] = WDATA[8 * (le ? 3 - x : x) +: 8];
        h = {v[a], v[2'(a + 2'h1)]};
        if (s == ptlm_pkg::SIZE_WORD) return {v[0], v[1], v[2], v[3]};
        if (s == ptlm_pkg::SIZE_HALF) return (32'(h) << (8 * (2 - a))) | {h, 16'h0};
        return (32'(v[a]) << (8 * (3 - a))) | {v[a], 24'h0} | (a == 2'h3 ? {8'h0, v[a], 16'h0} : 32'h0);
    endfunction

    function automatic logic [31:0] er(input logic [3:0] sel, input logic le);
        logic [31:0] r;
        r = 32'h0;
        for (int k = 0; k < 4; k++) if (sel[k]) r[8 * k +: 8] = 8'hD0 + 8'(le ? 3 - k : k);
        return r;
    endfunction

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic take_cpl(input logic wr, input logic [31:0] exp);
        for (int t = 0; t < 50 && cpl_valid_o !== 1'h1; t++) @(negedge clock_i);
        check("cpl_write", 32'(cpl_write_o), 32'(wr));
        check("cpl_rdata", cpl_rdata_o, exp);
        cpl_ready_i = 1'h1;
        @(negedge clock_i);
        cpl_ready_i = 1'h0;
    endtask

    task automatic run(input ptlm_row_t r, input logic wcpl);
        logic le;
        le = r.gbos[0] ^ r.inv[0];
        plan(~r.be_n, le, r.pw[1:0]);
        @(negedge clock_i);
        lg.delete();
        req_valid_i = 1'h1;
        req_write_i = r.wr[0];
        req_be_n_i = r.be_n;
        global_byte_order_select_i = r.gbos[0];
        image_order_invert_i = r.inv[0];
        port_width_field_i = r.pw[1:0];
        slow = r.slow[0];
        for (int t = 0; t < 50 && req_ready_o !== 1'h1; t++) @(negedge clock_i);
        @(negedge clock_i);
        req_valid_i = 1'h0;
        for (int t = 0; t < 50 && (lg.size() < qs.size() || lb_valid_o !== 1'h0); t++) @(negedge clock_i);
        check("cycles", 32'(lg.size()), 32'(r.n));
        for (int i = 0; i < qs.size() && i < lg.size(); i++) begin
            check("size", 32'(lg[i].s), 32'(qs[i]));
            check("addr", lg[i].a, {ADDR[31:2], qa[i]});
            check("dir", 32'(lg[i].w), 32'(r.wr[0]));
            if (r.wr[0]) check("wdata", lg[i].d, ew(qs[i], qa[i], le));
        end
        if (wcpl) take_cpl(r.wr[0], r.wr[0] ? 32'h0 : er(~r.be_n, le));
    endtask

    task automatic report_and_stop;
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // ******************
    // Sequence
    // ******************
    initial begin
        repeat (8) @(posedge clock_i);
        @(negedge clock_i);
        check("rst req_ready", 32'(req_ready_o), 32'h1);
        check("rst lb_valid", 32'({lb_valid_o, cpl_valid_o, transfer_size_code_o}), 32'h0);
        rst_i = 1'h0;
        foreach (rows[i]) begin
            run(rows[i], 1'h1);
            $display("row %0d done", i);
        end
        // Completions held back: third request stalls the mapper
        for (int i = 0; i < 3; i++) run(rows[i], 1'h0);
        repeat (4) @(negedge clock_i);
        check("full req_ready", 32'(req_ready_o), 32'h0);
        for (int i = 0; i < 3; i++) take_cpl(1'h1, 32'h0);
        check("drained", 32'(cpl_valid_o), 32'h0);
        $display("buffer test done");
        // Reset lands inside a slow split read
        slow = 1'h1;
        port_width_field_i = ptlm_pkg::PW_8;
        req_be_n_i = 4'h0;
        req_write_i = 1'h0;
        req_valid_i = 1'h1;
        @(negedge clock_i);
        req_valid_i = 1'h0;
        @(negedge clock_i);
        rst_i = 1'h1;
        @(negedge clock_i);
        check("mid rst lb_valid", 32'({lb_valid_o, cpl_valid_o}), 32'h0);
        check("mid rst req_ready", 32'(req_ready_o), 32'h1);
        rst_i = 1'h0;
        run(rows[20], 1'h1);
        $display("reset test done");
        report_and_stop();
    end
endmodule // tb
`default_nettype wire
